// *** afc_pkg.sv ***
// Package with the shared types and constants of the frame and conversion-start control block.
package afc_pkg;

  // ----------------------------------------------------------------
  // Conversion modes and counter limits
  // ----------------------------------------------------------------
  localparam logic [1:0] AFC_MODE_EOC    = 2'h0;
  localparam logic [1:0] AFC_MODE_SELECT = 2'h1;
  localparam logic [3:0] AFC_EDGE_LAST   = 4'hf;
  localparam logic [3:0] AFC_CONV_CYCLES = 4'h8;

  // ----------------------------------------------------------------
  // Pin groups
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cs_n;
    logic frame_sync;
    logic sclk;
    logic conv_start_n;
    logic power_down_n;
  } afc_pins_t;

  typedef struct packed {
    logic sample_window;
    logic conv_busy;
    logic serial_in_en;
    logic serial_out_en;
    logic eoc_int_n;
    logic powered_up;
  } afc_status_t;

endpackage : afc_pkg

// *** afc_ctrl.sv ***
// Frame, serial-input gating and conversion-start control of a serial converter.
`timescale 1ns/100ps

// How it works
// - While chip select is high, conversion-start low opens sampling; rising closes it.
// - In mode 01, sampling held off until chip select returns high.
// - Conversion-start rising edge with chip select high begins a conversion.
// - End-of-conversion output low from sampling end until result is ready.
// - End-of-conversion signalling used only in conversion mode 00.
// - Shared output selectable as interrupt instead of end-of-conversion.
// - Interrupt falls when data ready; cleared by chip select fall or frame sync.
// - Frame sync low when chip select falls keeps serial input disabled.
// - Frame sync falling edge with chip select low clears edge counter and enables serial input.
// - Serial input disabled at 16 counted edges or chip select rising.
// - Chip select falling clears counter, enables output driver and, with frame sync high, the input.
// - Serial input bit shifted into input register on serial clock rise.
// - Power-down low idles converter; restart on chip select, frame sync, conversion-start.
module afc_ctrl
  import afc_pkg::*;
#(
  parameter int IN_WIDTH = 16
)(
  // Clock and reset
  input  wire logic                clk_in,
  input  wire logic                reset_n_in,
  // Host pins
  input  wire logic                cs_n_in,
  input  wire logic                frame_sync_in,
  input  wire logic                sclk_in,
  input  wire logic                serial_in_in,
  input  wire logic                conv_start_n_in,
  input  wire logic                power_down_n_in,
  // Configuration straps
  input  wire logic [1:0]          conv_mode_in,
  input  wire logic                int_select_in,
  // Outputs
  output logic                     eoc_int_n_out,
  output logic                     serial_out_en_out,
  output logic                     serial_in_en_out,
  output logic                     sample_window_out,
  output logic                     conv_busy_out,
  output logic                     conv_done_out,
  output logic [IN_WIDTH-1:0]      input_word_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    afc_pins_t             sync1;
    afc_pins_t             sync2;
    afc_pins_t             prev;
    logic                  din1;
    logic                  din2;
    logic [3:0]            edge_cnt;
    logic                  edge_full;
    logic                  sdi_en;
    logic                  sdo_en;
    logic                  window;
    logic                  busy;
    logic [3:0]            conv_cnt;
    logic                  done;
    logic                  eoc_n;
    logic                  powered;
    logic [IN_WIDTH-1:0]   shreg;
  } afc_state_t;

  afc_state_t st;
  afc_state_t next_st;

  afc_pins_t  raw;
  logic       cs_fall;
  logic       cs_rise;
  logic       fs_fall;
  logic       cst_fall;
  logic       cst_rise;
  logic       sclk_rise;
  logic       sclk_edge;

  assign raw = '{cs_n: cs_n_in, frame_sync: frame_sync_in, sclk: sclk_in,
                 conv_start_n: conv_start_n_in, power_down_n: power_down_n_in};

  // Edges are found on the second stage only, never on the first.
  assign cs_fall   =  st.prev.cs_n         & ~st.sync2.cs_n;
  assign cs_rise   = ~st.prev.cs_n         &  st.sync2.cs_n;
  assign fs_fall   =  st.prev.frame_sync   & ~st.sync2.frame_sync;
  assign cst_fall  =  st.prev.conv_start_n & ~st.sync2.conv_start_n;
  assign cst_rise  = ~st.prev.conv_start_n &  st.sync2.conv_start_n;
  assign sclk_rise = ~st.prev.sclk         &  st.sync2.sclk;
  assign sclk_edge =  st.prev.sclk         ^  st.sync2.sclk;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st       = st;
    next_st.sync1 = raw;
    next_st.sync2 = st.sync1;
    next_st.prev  = st.sync2;
    next_st.din1  = serial_in_in;
    next_st.din2  = st.din1;
    next_st.done  = 1'b0;

    // Powered-down state drops any sampling or conversion in flight.
    if (!st.sync2.power_down_n)
    begin
      next_st.powered = 1'b0;
      next_st.window  = 1'b0;
      next_st.busy    = 1'b0;
    end
    else if (!st.powered && (cs_fall || fs_fall || cst_fall))
    begin
      next_st.powered = 1'b1;
    end

    // Serial input gating and edge counting.
    if (st.sdi_en && sclk_edge && !st.edge_full)
    begin
      next_st.edge_cnt = st.edge_cnt + 4'h1;
      if (st.edge_cnt == AFC_EDGE_LAST)
      begin
        next_st.edge_full = 1'b1;
        next_st.sdi_en    = 1'b0;
      end
    end
    if (st.sdi_en && sclk_rise)
    begin
      next_st.shreg = {st.shreg[IN_WIDTH-2:0], st.din2};
    end
    if (cs_fall)
    begin
      next_st.edge_cnt  = 4'h0;
      next_st.edge_full = 1'b0;
      next_st.sdo_en    = 1'b1;
      // A low frame sync at select time holds the input off until a frame arrives.
      next_st.sdi_en    = st.sync2.frame_sync;
    end
    if (fs_fall && !st.sync2.cs_n)
    begin
      next_st.edge_cnt  = 4'h0;
      next_st.edge_full = 1'b0;
      next_st.sdi_en    = 1'b1;
    end
    if (cs_rise)
    begin
      next_st.sdi_en = 1'b0;
      next_st.sdo_en = 1'b0;
    end

    // Sampling window under conversion-start, only while deselected.
    if (st.powered && st.sync2.power_down_n)
    begin
      if (st.sync2.cs_n && !st.sync2.conv_start_n && !st.busy)
      begin
        next_st.window = 1'b1;
      end
      if (st.window && cst_rise)
      begin
        next_st.window   = 1'b0;
      end
      if (cst_rise && st.sync2.cs_n && !st.busy)
      begin
        next_st.busy     = 1'b1;
        next_st.conv_cnt = 4'h0;
        if (conv_mode_in == AFC_MODE_EOC && !int_select_in)
        begin
          next_st.eoc_n = 1'b0;
        end
      end
    end
    if (st.busy)
    begin
      next_st.conv_cnt = st.conv_cnt + 4'h1;
      if (st.conv_cnt == AFC_CONV_CYCLES)
      begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
        if (int_select_in)
        begin
          next_st.eoc_n = 1'b0;
        end
        else
        begin
          next_st.eoc_n = 1'b1;
        end
      end
    end
    if (int_select_in && (cs_fall || fs_fall) && !(st.busy && st.conv_cnt == AFC_CONV_CYCLES))
    begin
      next_st.eoc_n = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      // Pin stages start at each pin's idle level (serial clock low, all else high), so no false edge follows reset.
      next_st_reset: st <= '{sync1: 5'h1b, sync2: 5'h1b, prev: 5'h1b,
                             eoc_n: 1'b1, powered: 1'b1, default: '0};
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign eoc_int_n_out     = st.eoc_n;
  assign serial_out_en_out = st.sdo_en;
  assign serial_in_en_out  = st.sdi_en;
  assign sample_window_out = st.window;
  assign conv_busy_out     = st.busy;
  assign conv_done_out     = st.done;
  assign input_word_out    = st.shreg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_no_window_selected;
    @(posedge clk_in) disable iff (!reset_n_in)
    (!st.sync2.cs_n && !st.window) |=> !st.window;
  endproperty
  a_no_window_selected: assert property (p_no_window_selected) else $error("Window opened while selected.");

  property p_conv_start;
    @(posedge clk_in) disable iff (!reset_n_in)
    (cst_rise && st.sync2.cs_n && st.powered && st.sync2.power_down_n && !st.busy) |=> st.busy;
  endproperty
  a_conv_start: assert property (p_conv_start) else $error("Conversion did not start.");

  property p_conv_len;
    @(posedge clk_in) disable iff (!reset_n_in)
    ($rose(st.busy) && st.sync2.power_down_n) |-> ##[9:10] (!st.busy || !st.sync2.power_down_n);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("Conversion length wrong.");

  property p_eoc_mode;
    @(posedge clk_in) disable iff (!reset_n_in)
    ($fell(st.eoc_n) && !int_select_in) |-> $past(conv_mode_in) == AFC_MODE_EOC;
  endproperty
  a_eoc_mode: assert property (p_eoc_mode) else $error("End-of-conversion outside mode 00.");

  property p_int_clear;
    @(posedge clk_in) disable iff (!reset_n_in)
    (int_select_in && cs_fall && !st.busy) |=> st.eoc_n;
  endproperty
  a_int_clear: assert property (p_int_clear) else $error("Interrupt not cleared.");

  property p_fs_enable;
    @(posedge clk_in) disable iff (!reset_n_in)
    (fs_fall && !st.sync2.cs_n && !cs_rise) |=> (st.sdi_en && st.edge_cnt == 4'h0);
  endproperty
  a_fs_enable: assert property (p_fs_enable) else $error("Frame sync did not enable input.");

  property p_cs_rise_off;
    @(posedge clk_in) disable iff (!reset_n_in)
    cs_rise |=> (!st.sdi_en && !st.sdo_en);
  endproperty
  a_cs_rise_off: assert property (p_cs_rise_off) else $error("Input still enabled after deselect.");

  property p_full_off;
    @(posedge clk_in) disable iff (!reset_n_in)
    (st.edge_full && !fs_fall && !cs_fall) |=> (!st.sdi_en && st.edge_full);
  endproperty
  a_full_off: assert property (p_full_off) else $error("Input enabled after 16 edges.");

  property p_cs_fall;
    @(posedge clk_in) disable iff (!reset_n_in)
    (cs_fall && st.sync2.frame_sync) |=> (st.sdi_en && st.sdo_en && st.edge_cnt == 4'h0);
  endproperty
  a_cs_fall: assert property (p_cs_fall) else $error("Select fall did not arm interface.");

  property p_powerdown;
    @(posedge clk_in) disable iff (!reset_n_in)
    !st.sync2.power_down_n |=> (!st.busy && !st.window);
  endproperty
  a_powerdown: assert property (p_powerdown) else $error("Activity while powered down.");

  c_conv: cover property (@(posedge clk_in) disable iff (!reset_n_in) $fell(st.busy));
  c_full: cover property (@(posedge clk_in) disable iff (!reset_n_in) $rose(st.edge_full));
  c_int:  cover property (@(posedge clk_in) disable iff (!reset_n_in) int_select_in && $fell(st.eoc_n));

endmodule : afc_ctrl

// *** afc_host_model.sv ***
// Host pin model for the frame and conversion-start block.
`timescale 1ns/100ps
module afc_host_model
(
  // Clock
  input  wire logic clk_in,
  // Host pins
  output logic      cs_n_out,
  output logic      frame_sync_out,
  output logic      sclk_out,
  output logic      serial_in_out,
  output logic      conv_start_n_out,
  output logic      power_down_n_out
);
  initial
  begin
    {cs_n_out, frame_sync_out, conv_start_n_out, power_down_n_out} = 4'hf;
    sclk_out      = 1'h0;
    serial_in_out = 1'h0;
  end

  task wait_clk(input int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask : wait_clk

  // The caller sets the sampling window by how long it waits between two calls.
  task drive(input logic cs, input logic fs, input logic cst, input logic pd);
    wait_clk(1);
    {cs_n_out, frame_sync_out, conv_start_n_out, power_down_n_out} = {cs, fs, cst, pd};
  endtask : drive

  // The serial clock idles low between frames; a released data line shows the inverse of its last bit.
  task shift(input logic [7:0] d, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      serial_in_out = d[i];
      wait_clk(4);
      sclk_out = 1'h1;
      wait_clk(4);
      sclk_out = 1'h0;
    end
    serial_in_out = ~serial_in_out;
  endtask : shift
endmodule : afc_host_model

// *** tb_top.sv ***
// Self-checking bench of the frame and conversion-start block.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb_top
  import afc_pkg::*;
;
  logic        clk_in     = 1'h0;
  logic        reset_n_in = 1'h0;
  logic [1:0]  conv_mode  = 2'h0;
  logic        int_sel    = 1'h0;
  logic        cs_n, frame_sync, sclk, serial_in, conv_start_n, power_down_n;
  logic        eoc_int_n, so_en, si_en, window, busy, done;
  logic [15:0] word;
  int          fail_count  = 0;
  int          check_count = 0;

  initial
  forever #12.5 clk_in = ~clk_in;

  afc_host_model i_host (.clk_in(clk_in), .cs_n_out(cs_n), .frame_sync_out(frame_sync), .sclk_out(sclk),
    .serial_in_out(serial_in), .conv_start_n_out(conv_start_n), .power_down_n_out(power_down_n));

  afc_ctrl i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .cs_n_in(cs_n), .frame_sync_in(frame_sync),
    .sclk_in(sclk), .serial_in_in(serial_in), .conv_start_n_in(conv_start_n), .power_down_n_in(power_down_n),
    .conv_mode_in(conv_mode), .int_select_in(int_sel), .eoc_int_n_out(eoc_int_n), .serial_out_en_out(so_en),
    .serial_in_en_out(si_en), .sample_window_out(window), .conv_busy_out(busy), .conv_done_out(done),
    .input_word_out(word));

  // Selector: 0 window, 1 busy, 2 done, 3 shared output, 4 input gate, 5 output driver.
  function automatic logic pick(input int s);
    case (s)
      0: return window;
      1: return busy;
      2: return done;
      3: return eoc_int_n;
      4: return si_en;
      default: return so_en;
    endcase
  endfunction : pick

  task wait_for(input int s, input logic v, input int lim);
    int n;
    n = 0;
    while (pick(s) !== v && n < lim)
    begin
      @(posedge clk_in);
      #1;
      n++;
    end
    `CHK("wait", v, pick(s))
    if (pick(s) !== v)
      give_verdict();
  endtask : wait_for

  task give_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  task setup(input logic [1:0] m, input logic i);
    i_host.wait_clk(1);
    conv_mode = m;
    int_sel   = i;
  endtask : setup

  task run_conv(output logic eoc_busy);
    i_host.drive(1, 1, 0, 1);
    wait_for(0, 1'h1, 12);
    i_host.wait_clk(6);
    i_host.drive(1, 1, 1, 1);
    wait_for(1, 1'h1, 12);
    `CHK("window", 1'h0, window)
    eoc_busy = eoc_int_n;
    wait_for(2, 1'h1, 16);
    i_host.wait_clk(2);
  endtask : run_conv

  task sc_eoc();
    logic e;
    setup(AFC_MODE_EOC, 1'h0);
    run_conv(e);
    `CHK("eoc low", 1'h0, e)
    `CHK("eoc end", 1'h1, eoc_int_n)
  endtask : sc_eoc

  task sc_int();
    logic e;
    setup(AFC_MODE_EOC, 1'h1);
    run_conv(e);
    `CHK("int set", 1'h0, eoc_int_n)
    i_host.drive(0, 1, 1, 1);
    wait_for(3, 1'h1, 12);
    i_host.drive(1, 1, 1, 1);
  endtask : sc_int

  task sc_mode01();
    setup(AFC_MODE_SELECT, 1'h0);
    i_host.drive(0, 1, 1, 1);
    i_host.drive(0, 1, 0, 1);
    i_host.wait_clk(8);
    `CHK("early window", 1'h0, window)
    i_host.drive(1, 1, 0, 1);
    wait_for(0, 1'h1, 12);
    i_host.drive(1, 1, 1, 1);
    wait_for(1, 1'h1, 12);
    i_host.wait_clk(2);
    `CHK("no eoc", 1'h1, eoc_int_n)
    wait_for(2, 1'h1, 16);
  endtask : sc_mode01

  task sc_frame_cs();
    i_host.drive(0, 1, 1, 1);
    wait_for(4, 1'h1, 12);
    `CHK("out en", 1'h1, so_en)
    i_host.shift(8'h52, 7);
    `CHK("in en 14", 1'h1, si_en)
    i_host.shift(8'h01, 1);
    wait_for(4, 1'h0, 12);
    `CHK("word", 8'ha5, word[7:0])
    i_host.drive(1, 1, 1, 1);
    wait_for(5, 1'h0, 12);
  endtask : sc_frame_cs

  task sc_frame_fs();
    i_host.drive(1, 0, 1, 1);
    i_host.drive(0, 0, 1, 1);
    i_host.wait_clk(8);
    `CHK("in en held", 1'h0, si_en)
    i_host.drive(0, 1, 1, 1);
    i_host.wait_clk(4);
    i_host.drive(0, 0, 1, 1);
    wait_for(4, 1'h1, 12);
    i_host.shift(8'h03, 2);
    i_host.drive(1, 1, 1, 1);
    wait_for(4, 1'h0, 12);
    `CHK("word fs", 2'h3, word[1:0])
  endtask : sc_frame_fs

  task sc_power_down_n();
    logic e;
    setup(AFC_MODE_EOC, 1'h0);
    i_host.drive(1, 1, 1, 0);
    i_host.wait_clk(6);
    i_host.drive(1, 1, 0, 0);
    i_host.wait_clk(8);
    i_host.drive(1, 1, 1, 0);
    i_host.wait_clk(6);
    `CHK("pd busy", 1'h0, busy)
    i_host.drive(1, 1, 1, 1);
    i_host.wait_clk(4);
    i_host.drive(0, 1, 1, 1);
    i_host.drive(1, 1, 1, 1);
    run_conv(e);
  endtask : sc_power_down_n

  initial
  begin
    repeat (10) @(posedge clk_in);
    #2;
    reset_n_in = 1'h1;
    i_host.wait_clk(4);
    sc_eoc();
    sc_int();
    sc_mode01();
    sc_frame_cs();
    sc_frame_fs();
    sc_power_down_n();
    give_verdict();
  end
endmodule : tb_top
